//--- core/psc_control.sv
// privilege level, stack select and processing state controller
`timescale 1ns/1ps
`include "psc_defs.svh"
`default_nettype none

module psc_control #(
	// format code that marks an access fault frame, and the words each kind
	// of frame gives back to the stack on return; plain defaults, to be set
	// to the frame layout of the core this block sits in
	parameter logic [3:0] FAULT_FORMAT = 4'h7,
	parameter logic [4:0] SHORT_FRAME_WORDS = 5'h04,
	parameter logic [4:0] FAULT_FRAME_WORDS = 5'h1e
) (
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// execute unit, same clock
	// pulses below are one cycle wide and on this clock, so no synchronisers
	input wire logic ins_valid,
	input wire logic [2:0] ins_op,
	input wire logic [15:0] ins_operand,
	input wire logic exc_req,
	input wire logic [1:0] exc_kind,
	input wire logic bus_error,
	input wire logic address_error,
	input wire logic handler_start,
	input wire logic [3:0] frame_format,
	input wire logic [15:0] frame_sw,
	input wire logic acc_prog,
	// external bus side and status
	// every output below comes straight from a register
	output logic [2:0] transfer_modifier_lines,
	output logic bus_enable,
	output logic [1:0] stack_select,
	output logic [31:0] active_sp,
	output logic push_state_word,
	output logic [15:0] pushed_state_word,
	output logic pipe_flush,
	output logic priv_violation,
	output logic restore_full_state,
	output logic [4:0] release_words,
	output logic reset_external,
	output logic [3:0] proc_state,
	output logic [15:0] processor_state_word
);

	// whole state in one struct: one process computes it, one registers it
	psc_pkg::psc_regs_t r_reg;
	psc_pkg::psc_regs_t r_next;
	// pointer picked by the current selection, registered one cycle later
	logic [31:0] act_sp;

	// ==========================================
	// combinational helpers
	// decodes that the next-state logic and the bus share
	logic sup;
	logic in_exc;
	logic fault;
	logic refused;
	logic entry_req;
	logic intr_entry;
	logic sw_write_ok;
	logic halt_now;
	logic sel_state;
	logic sel_usp;
	logic sel_isp;
	logic sel_tsp;
	logic sel_actsp;
	logic wr_commit;
	logic wr_usp;
	logic wr_isp;
	logic wr_tsp;
	logic privileged;
	logic is_sw_op;
	logic [15:0] sw_new;
	logic mapped;
	logic [31:0] rd_mux;
	logic fault_frame;
	psc_pkg::psc_op_t op;

	// op codes arrive as a plain bus from the execute unit
	assign op = psc_pkg::psc_op_t'(ins_op);
	// only the privilege flag decides, stack select is not looked at
	assign sup = r_reg.sw[`PSC_SW_S];
	assign in_exc = (r_reg.st == psc_pkg::PSC_EXCEPT);
	// everything that writes the state word or stops the core is privileged;
	// reset counts as well, as it drives the system reset line
	assign is_sw_op = (op == psc_pkg::PSC_OP_MOVE_SW) || (op == psc_pkg::PSC_OP_AND_SW) ||
		(op == psc_pkg::PSC_OP_XOR_SW) || (op == psc_pkg::PSC_OP_OR_SW) ||
		(op == psc_pkg::PSC_OP_RETURN);
	assign privileged = is_sw_op || (op == psc_pkg::PSC_OP_STOP) ||
		(op == psc_pkg::PSC_OP_RESET);
	// any other format is a short frame: word and counter only
	assign fault_frame = (frame_format == FAULT_FORMAT);

	// ==========================================
	// event qualifiers for the state machine
	// named once here so that every branch below tests the same thing
	// an access fault outranks a request or an instruction in the same cycle
	assign fault = bus_error || address_error;
	// a privileged class seen at user level is refused, never executed
	assign refused = ins_valid && privileged && !sup;
	// any of these starts exception processing from normal state
	assign entry_req = exc_req || fault || refused;
	// only a clean interrupt request drops the stack select on entry;
	// a fault in the same cycle is taken as the fault instead
	assign intr_entry = exc_req && !fault &&
		(exc_kind == psc_pkg::PSC_EXC_INTR);
	// privileged work that may run: supervisor level and nothing pending
	assign sw_write_ok = ins_valid && privileged && sup && !exc_req && !fault;
	// a second fault before the handler starts cannot be recovered, since
	// the frame of the first one is not complete yet
	assign halt_now = in_exc && fault;

	// ==========================================
	// register selects
	// offsets are byte addresses of aligned 32-bit words
	// one decode shared by reads and writes keeps the two maps in step
	assign sel_state = (paddr == `PSC_OFF_STATE);
	assign sel_usp = (paddr == `PSC_OFF_USP);
	assign sel_isp = (paddr == `PSC_OFF_ISP);
	assign sel_tsp = (paddr == `PSC_OFF_TSP);
	assign sel_actsp = (paddr == `PSC_OFF_ACTSP);
	// a write lands only in the access cycle that the slave has made ready
	assign wr_commit = psel && penable && pwrite && r_reg.pready;
	// state word and active pointer are read only from software, so a
	// stray write cannot bypass the privilege checks
	assign wr_usp = wr_commit && sel_usp;
	assign wr_isp = wr_commit && sel_isp;
	assign wr_tsp = wr_commit && sel_tsp;

	// new state word from the state word writers
	always_comb begin
		case (op)
			psc_pkg::PSC_OP_MOVE_SW: sw_new = ins_operand;
			psc_pkg::PSC_OP_AND_SW: sw_new = r_reg.sw & ins_operand;
			psc_pkg::PSC_OP_XOR_SW: sw_new = r_reg.sw ^ ins_operand;
			psc_pkg::PSC_OP_OR_SW: sw_new = r_reg.sw | ins_operand;
			psc_pkg::PSC_OP_RETURN: sw_new = frame_sw;
			// stop and reset leave the word alone: only the listed writers
			// may touch the stack select
			default: sw_new = r_reg.sw;
		endcase
	end

	// apb address decode
	// unmapped offsets read zero and raise an error
	always_comb begin
		mapped = 1'b1;
		rd_mux = 32'h0000_0000;
		if (sel_state) begin
			rd_mux = {12'h000, r_reg.st, r_reg.sw};
		end else if (sel_usp) begin
			rd_mux = r_reg.user_stack_pointer;
		end else if (sel_isp) begin
			rd_mux = r_reg.interrupt_stack_pointer;
		end else if (sel_tsp) begin
			rd_mux = r_reg.tsp;
		end else if (sel_actsp) begin
			rd_mux = act_sp;
		end else begin
			mapped = 1'b0;
		end
	end

	// ==========================================
	// next state
	always_comb begin
		r_next = r_reg;
		// one-cycle strobes fall back every cycle
		r_next.push = 1'b0;
		r_next.flush = 1'b0;
		r_next.priv_viol = 1'b0;
		r_next.restore_full = 1'b0;
		r_next.release_words = 5'h00;
		r_next.reset_ext = 1'b0;

		case (r_reg.st)
			psc_pkg::PSC_NORMAL: begin
				if (entry_req) begin
					// the pushed word is the one in force before entry; the
					// privilege flag goes up in the same edge but after the copy
					r_next.st = psc_pkg::PSC_EXCEPT;
					r_next.push = 1'b1;
					r_next.saved_sw = r_reg.sw;
					r_next.sw[`PSC_SW_S] = 1'b1;
					if (intr_entry) begin
						r_next.sw[`PSC_SW_M] = 1'b0;
					end
					// refused instruction raises a privilege violation when no request or fault comes in the same cycle
					r_next.priv_viol = refused && !exc_req && !fault;
				end else if (sw_write_ok) begin
					// supervisor level: word writers, stop and reset take effect
					r_next.sw = sw_new;
					// the new level may change the fetch space, refetch all
					if (is_sw_op) begin
						r_next.flush = 1'b1;
					end
					// stop: no bus cycles until an exception wakes the core
					if (op == psc_pkg::PSC_OP_STOP) begin
						r_next.st = psc_pkg::PSC_STOPPED;
					end
					// reset pulses the external reset line for one cycle
					if (op == psc_pkg::PSC_OP_RESET) begin
						r_next.reset_ext = 1'b1;
					end
					if (op == psc_pkg::PSC_OP_RETURN) begin
						// frame format picks restore depth and stack release
						r_next.restore_full = fault_frame;
						r_next.release_words = fault_frame ?
							FAULT_FRAME_WORDS : SHORT_FRAME_WORDS;
					end
				end
			end
			psc_pkg::PSC_STOPPED: begin
				// only an exception wakes a stopped core
				// faults cannot arrive: no bus cycles run while stopped
				if (exc_req) begin
					r_next.st = psc_pkg::PSC_EXCEPT;
					r_next.push = 1'b1;
					r_next.saved_sw = r_reg.sw;
					r_next.sw[`PSC_SW_S] = 1'b1;
					if (exc_kind == psc_pkg::PSC_EXC_INTR) begin
						r_next.sw[`PSC_SW_M] = 1'b0;
					end
				end
			end
			psc_pkg::PSC_EXCEPT: begin
				// a second fault before the handler runs is fatal
				if (halt_now) begin
					r_next.st = psc_pkg::PSC_HALTED;
				end else if (handler_start) begin
					r_next.st = psc_pkg::PSC_NORMAL;
				end
			end
			default: begin
				// halted: nothing but reset changes state or word; bus pointer writes still land
				// the word is kept so that a debugger can see where it stopped
				r_next.st = psc_pkg::PSC_HALTED;
				r_next.sw = r_reg.sw;
			end
		endcase

		// bus cycles only in normal or exception processing
		// taken from the next state so the enable drops with the state change
		r_next.bus_en = (r_next.st == psc_pkg::PSC_NORMAL) ||
			(r_next.st == psc_pkg::PSC_EXCEPT);
		// privilege class follows the word in force for the cycle
		// exception processing is supervisor whatever the word holds
		if (r_next.sw[`PSC_SW_S] || r_next.st == psc_pkg::PSC_EXCEPT) begin
			r_next.tm = acc_prog ? `PSC_TM_SUP_PROG : `PSC_TM_SUP_DATA;
			r_next.sp_sel = r_next.sw[`PSC_SW_M] ? `PSC_SP_TASK : `PSC_SP_INTR;
		end else begin
			r_next.tm = acc_prog ? `PSC_TM_USER_PROG : `PSC_TM_USER_DATA;
			r_next.sp_sel = `PSC_SP_USER;
		end

		// registered copy of the pointer picked by the selection of the
		// cycle before; software reads the live one over the bus
		r_next.act_sp = act_sp;

		// apb: setup cycle prepares the answer, access cycle commits;
		// ready and error stand for the access cycle only
		r_next.pready = 1'b0;
		r_next.pslverr = 1'b0;
		if (psel && !penable) begin
			r_next.pready = 1'b1;
			r_next.prdata = pwrite ? 32'h0000_0000 : rd_mux;
			r_next.pslverr = !mapped;
		end
		// pointer writes, at most one per access cycle
		if (wr_usp) begin
			r_next.user_stack_pointer = pwdata;
		end else if (wr_isp) begin
			r_next.interrupt_stack_pointer = pwdata;
		end else if (wr_tsp) begin
			r_next.tsp = pwdata;
		end
	end

	// ==========================================
	// live pointer for the current selection
	always_comb begin
		case (r_reg.sp_sel)
			`PSC_SP_TASK: act_sp = r_reg.tsp;
			`PSC_SP_INTR: act_sp = r_reg.interrupt_stack_pointer;
			default: act_sp = r_reg.user_stack_pointer;
		endcase
	end

	// ==========================================
	// registers; reset comes up supervisor, interrupt pointer
	// no strobe is high out of reset, so the bus may start at the first
	// edge after release
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			r_reg.st <= psc_pkg::PSC_NORMAL;
			r_reg.sw <= `PSC_SW_RESET;
			r_reg.saved_sw <= 16'h0000;
			r_reg.user_stack_pointer <= 32'h0000_0000;
			r_reg.interrupt_stack_pointer <= 32'h0000_0000;
			r_reg.tsp <= 32'h0000_0000;
			r_reg.tm <= `PSC_TM_SUP_PROG;
			r_reg.bus_en <= 1'b1;
			r_reg.sp_sel <= `PSC_SP_INTR;
			r_reg.push <= 1'b0;
			r_reg.flush <= 1'b0;
			r_reg.priv_viol <= 1'b0;
			r_reg.restore_full <= 1'b0;
			r_reg.release_words <= 5'h00;
			r_reg.reset_ext <= 1'b0;
			r_reg.pready <= 1'b0;
			r_reg.prdata <= 32'h0000_0000;
			r_reg.pslverr <= 1'b0;
			r_reg.act_sp <= 32'h0000_0000;
		end else begin
			r_reg <= r_next;
		end
	end

	// ==========================================
	// outputs, all straight from flops
	// nothing combinational reaches a pin, so far-side timing stays clean
	assign prdata = r_reg.prdata;
	assign pready = r_reg.pready;
	assign pslverr = r_reg.pslverr;
	assign transfer_modifier_lines = r_reg.tm;
	assign bus_enable = r_reg.bus_en;
	assign stack_select = r_reg.sp_sel;
	assign active_sp = r_reg.act_sp;
	assign push_state_word = r_reg.push;
	assign pushed_state_word = r_reg.saved_sw;
	assign pipe_flush = r_reg.flush;
	assign priv_violation = r_reg.priv_viol;
	assign restore_full_state = r_reg.restore_full;
	assign release_words = r_reg.release_words;
	assign reset_external = r_reg.reset_ext;
	assign proc_state = r_reg.st;
	assign processor_state_word = r_reg.sw;

endmodule

`default_nettype wire

//--- core/psc_defs.svh
// constants for the privilege and processing state controller
`ifndef PSC_DEFS_SVH
`define PSC_DEFS_SVH

// ==========================================
// state word layout and reset value
`define PSC_SW_S 13
`define PSC_SW_M 12
`define PSC_SW_RESET 16'h2700

// ==========================================
// apb register byte offsets
`define PSC_OFF_STATE 12'h000
`define PSC_OFF_USP 12'h004
`define PSC_OFF_ISP 12'h008
`define PSC_OFF_TSP 12'h00c
`define PSC_OFF_ACTSP 12'h010

// ==========================================
// transfer modifier codes
`define PSC_TM_USER_DATA 3'h1
`define PSC_TM_USER_PROG 3'h2
`define PSC_TM_SUP_DATA 3'h5
`define PSC_TM_SUP_PROG 3'h6

// ==========================================
// active stack pointer selection codes
`define PSC_SP_USER 2'h0
`define PSC_SP_INTR 2'h1
`define PSC_SP_TASK 2'h2

`endif

//--- core/psc_pkg.sv
// types for the privilege and processing state controller
package psc_pkg;

	// processing state, one-hot
	typedef enum logic [3:0] {
		PSC_NORMAL = 4'h1,
		PSC_EXCEPT = 4'h2,
		PSC_STOPPED = 4'h4,
		PSC_HALTED = 4'h8
	} psc_state_t;

	// instruction classes reported by the execute unit
	typedef enum logic [2:0] {
		PSC_OP_OTHER = 3'h0,
		PSC_OP_MOVE_SW = 3'h1,
		PSC_OP_AND_SW = 3'h2,
		PSC_OP_XOR_SW = 3'h3,
		PSC_OP_OR_SW = 3'h4,
		PSC_OP_RETURN = 3'h5,
		PSC_OP_STOP = 3'h6,
		PSC_OP_RESET = 3'h7
	} psc_op_t;

	// exception causes
	typedef enum logic [1:0] {
		PSC_EXC_INTR = 2'h0,
		PSC_EXC_TRAP = 2'h1,
		PSC_EXC_TRACE = 2'h2,
		PSC_EXC_OTHER = 2'h3
	} psc_exc_t;

	// complete state of the controller
	typedef struct packed {
		psc_state_t st;
		logic [15:0] sw;
		logic [15:0] saved_sw;
		logic [31:0] user_stack_pointer;
		logic [31:0] interrupt_stack_pointer;
		logic [31:0] tsp;
		logic [31:0] act_sp;
		logic [2:0] tm;
		logic bus_en;
		logic [1:0] sp_sel;
		logic push;
		logic flush;
		logic priv_viol;
		logic restore_full;
		logic [4:0] release_words;
		logic reset_ext;
		logic pready;
		logic [31:0] prdata;
		logic pslverr;
	} psc_regs_t;

endpackage

//--- test/psc_control_chk.sv
// assertion checker for the privilege state controller ports
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// checker
module psc_chk (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ins_valid,
	input wire logic [2:0] ins_op,
	input wire logic exc_req,
	input wire logic [1:0] exc_kind,
	input wire logic bus_error,
	input wire logic address_error,
	input wire logic [2:0] transfer_modifier_lines,
	input wire logic bus_enable,
	input wire logic [1:0] stack_select,
	input wire logic push_state_word,
	input wire logic [15:0] pushed_state_word,
	input wire logic priv_violation,
	input wire logic [3:0] proc_state,
	input wire logic [15:0] processor_state_word
);
	default clocking @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	// shorthand for the conditions below
	wire logic flt = bus_error || address_error;
	wire logic sup = processor_state_word[13];
	wire logic nrm = proc_state == 4'h1;
	wire logic exc = proc_state == 4'h2;
	chk_fault_halts: assert property (exc && flt |=> proc_state == 4'h8)
		else $error("fault in exception not halted");
	chk_halt_holds: assert property (proc_state == 4'h8 |=> proc_state == 4'h8
		&& $stable(processor_state_word)) else $error("halt left");
	chk_no_bus: assert property (proc_state[3:2] != 2'h0 |-> !bus_enable)
		else $error("bus cycles while stopped");
	chk_stack_sel: assert property (stack_select == (!sup ? 2'h0 :
		processor_state_word[12] ? 2'h2 : 2'h1)) else $error("wrong stack");
	chk_exc_super: assert property (exc |-> sup && transfer_modifier_lines[2])
		else $error("exception not supervisor");
	// while the level is steady, the modifier code carries the same level as the word
	chk_tm_class: assert property (bus_enable && $stable(sup)
		|-> transfer_modifier_lines[2] == sup) else $error("wrong privilege code");
	chk_intr_entry: assert property (nrm && exc_req && exc_kind == 2'h0 |=>
		push_state_word && sup && !processor_state_word[12]
		&& pushed_state_word == $past(processor_state_word)) else $error("bad entry");
	chk_user_refuse: assert property (nrm && ins_valid && !sup && ins_op != 3'h0
		&& !exc_req && !flt |=> priv_violation && exc) else $error("privileged op ran");
endmodule
bind psc_control psc_chk psc_chk_i (.*);
`default_nettype wire

//--- test/psc_bus_partner.sv
// far-side model: the system bus counting accesses by class
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// bus partner
module psc_bus_partner (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [2:0] transfer_modifier_lines,
	input wire logic bus_enable,
	output int bus_cycles,
	output int user_cycles
);
	// every enabled cycle is one access; a user code has bit 2 low
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bus_cycles <= 0;
			user_cycles <= 0;
		end else if (bus_enable) begin
			bus_cycles <= bus_cycles + 1;
			user_cycles <= user_cycles + 32'(!transfer_modifier_lines[2]);
		end
	end
endmodule
`default_nettype wire

//--- test/psc_control_tb_top.sv
// self-checking bench for the privilege state controller
`timescale 1ns/1ps
`default_nettype none
module psc_control_tb_top;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, ins_valid, exc_req, e;
	logic bus_error, address_error, handler_start, acc_prog, bus_enable, push_state_word;
	logic pipe_flush, priv_violation, restore_full_state, reset_external;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, active_sp, r, user_stack_pointer, interrupt_stack_pointer, tsp;
	logic [2:0] ins_op, transfer_modifier_lines, o;
	logic [15:0] ins_operand, frame_sw, pushed_state_word, processor_state_word, w, v;
	logic [1:0] exc_kind, stack_select;
	logic [3:0] frame_format, proc_state;
	logic [4:0] release_words;
	int err_count, cmp_count, cyc, bus_cycles, user_cycles, n;
	psc_control psc_control_i (.*);
	psc_bus_partner psc_bus_partner_i (.*);
	// ==========================================
	// clock, timeout and shared tasks
	initial begin
		pclk = 1'b0;
		forever #20 pclk = ~pclk;
	end
	// a hang ends the run as a failure
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 20000) begin
			err_count++;
			stop_test();
		end
	end
	task automatic stop_test();
		$display("errors %0d comparisons %0d", err_count, cmp_count);
		if (err_count == 0 && cmp_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			err_count++;
			$display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	// outside reset is the only way out of halt
	task automatic rst();
		presetn <= 1'b0;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
	endtask
	// one transfer; read data and error are taken at the ready edge
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	// one-cycle core event; outputs are read once its edge has landed
	task automatic act(input logic iv, input logic [2:0] op, input logic [15:0] val,
		input logic er, input logic [1:0] k, input logic [1:0] f, input logic h);
		ins_valid <= iv;
		ins_op <= op;
		ins_operand <= val;
		frame_sw <= val;
		exc_req <= er;
		exc_kind <= k;
		{address_error, bus_error} <= f;
		handler_start <= h;
		@(posedge pclk);
		{ins_valid, exc_req, address_error, bus_error, handler_start} <= 5'h0;
		@(posedge pclk);
	endtask
	task automatic ins(input logic [2:0] op, input logic [15:0] val);
		act(1'b1, op, val, 1'b0, 2'h0, 2'h0, 1'b0);
	endtask
	task automatic exc(input logic [1:0] k);
		act(1'b0, 3'h0, 16'h0, 1'b1, k, 2'h0, 1'b0);
	endtask
	task automatic hs();
		act(1'b0, 3'h0, 16'h0, 1'b0, 2'h0, 2'h0, 1'b1);
	endtask
	function automatic logic [1:0] sel(input logic [15:0] s);
		return !s[13] ? 2'h0 : s[12] ? 2'h2 : 2'h1;
	endfunction
	// ==========================================
	// main sequence
	initial begin
		{presetn, psel, penable, pwrite, ins_valid, exc_req} = 6'h0;
		{bus_error, address_error, handler_start, paddr, pwdata} = '0;
		{ins_op, ins_operand, frame_sw, exc_kind, frame_format} = '0;
		acc_prog = 1'b1;
		n = $urandom(32'he6aa8cce);
		rst();
		chk(proc_state, 4'h1);
		chk(processor_state_word, 16'h2700);
		chk(stack_select, 2'h1);
		chk(transfer_modifier_lines, 3'h6);
		user_stack_pointer = $urandom;
		interrupt_stack_pointer = $urandom;
		tsp = $urandom;
		apb(1'b1, 12'h004, user_stack_pointer);
		apb(1'b1, 12'h008, interrupt_stack_pointer);
		apb(1'b1, 12'h00c, tsp);
		apb(1'b0, 12'h010, 32'h0);
		chk(r, interrupt_stack_pointer);
		apb(1'b0, 12'h020, 32'h0);
		chk(e, 1'b1);
		ins(3'h7, 16'h0000);
		chk(reset_external, 1'b1);
		chk(processor_state_word, 16'h2700);
		ins(3'h1, 16'h3000);
		chk(pipe_flush, 1'b1);
		apb(1'b0, 12'h010, 32'h0);
		chk(r, tsp);
		ins(3'h1, 16'h1000);
		acc_prog <= 1'b0;
		apb(1'b0, 12'h010, 32'h0);
		chk(r, user_stack_pointer);
		chk(active_sp, user_stack_pointer);
		chk(transfer_modifier_lines, 3'h1);
		chk(user_cycles > 0, 1'b1);
		// stop at user level with the stack select set must be refused
		ins(3'h6, 16'h2000);
		chk(priv_violation, 1'b1);
		chk(pushed_state_word, 16'h1000);
		chk(processor_state_word[13], 1'b1);
		hs();
		chk(proc_state, 4'h1);
		acc_prog <= 1'b1;
		for (int k = 1; k < 4; k++) begin
			ins(3'h1, 16'h0000);
			exc(2'(k));
			chk(proc_state, 4'h2);
			hs();
		end
		ins(3'h5, 16'h0300);
		chk(processor_state_word, 16'h0300);
		chk(release_words, 5'h04);
		exc(2'h0);
		hs();
		frame_format <= 4'h7;
		ins(3'h5, 16'h2700);
		chk(restore_full_state, 1'b1);
		chk(release_words, 5'h1e);
		// random state word writers; an interrupt brings back supervisor
		w = 16'h2700;
		for (int i = 0; i < 24; i++) begin
			v = 16'($urandom);
			o = 3'($urandom_range(4, 1));
			ins(o, v);
			w = o == 3'h1 ? v : o == 3'h2 ? w & v : o == 3'h3 ? w ^ v : w | v;
			chk(processor_state_word[13:12], w[13:12]);
			chk(stack_select, sel(w));
			if (!w[13]) begin
				exc(2'h0);
				hs();
				w[13:12] = 2'b10;
			end
		end
		ins(3'h6, 16'h2700);
		chk(proc_state, 4'h4);
		n = bus_cycles;
		repeat (4) @(posedge pclk);
		chk(bus_cycles, n);
		exc(2'h0);
		chk(proc_state, 4'h2);
		// each access fault in mid exception halts until reset
		for (int j = 1; j < 3; j++) begin
			rst();
			exc(2'h1);
			act(1'b0, 3'h0, 16'h0, 1'b0, 2'h0, 2'(j), 1'b0);
			n = bus_cycles;
			hs();
			ins(3'h1, 16'h0000);
			chk(proc_state, 4'h8);
			chk(processor_state_word, 16'h2700);
			chk(bus_cycles, n);
		end
		rst();
		chk(proc_state, 4'h1);
		stop_test();
	end
endmodule
`default_nettype wire
